// ### hdl/mpc_map.vh
`ifndef MPC_MAP_VH
`define MPC_MAP_VH
// Application-tag page
`define MPC_AT_PAGE_CODE 6'h0a
`define MPC_AT_SUBPAGE 8'h02
`define MPC_AT_HDR_BYTES 16'h0010
`define MPC_AT_DESC_BYTES 16'h0018
`define MPC_AT_LEN_ADJ 16'h0004
`define MPC_AT_LAST_BIT 7
`define MPC_AT_TAG_POS 6
`define MPC_AT_LBA_POS 8
`define MPC_AT_CNT_POS 16
`define MPC_AT_MAX_DESC 8
`define MPC_AT_IDX_W 3
// Notch page
`define MPC_NP_PAGE_CODE 8'h0c
`define MPC_NP_PAGE_LEN 8'h16
`define MPC_NP_BYTE2 8'h80
`define MPC_NP_MAX_NOTCH 16'h0010
`define MPC_NP_PAGES_NOTCHED 64'h0000_0000_0000_100c
// Protocol-specific logical unit page
`define MPC_PL_PAGE_CODE 8'h18
`define MPC_PL_PAGE_LEN 8'h06
`define MPC_PL_PROTO_ID 4'h6
`define MPC_PL_RETRY_POS 4
// Sense values
`define MPC_SK_ILLEGAL_REQ 4'h5
`define MPC_ASC_INV_PARAM 8'h26
`define MPC_ASCQ_INV_PARAM 8'h00
`endif

// ### hdl/mpc_mode_page.v
`timescale 1ns/1ps
`include "mpc_map.vh"
module mpc_mode_page (
    input wire clk, // Clock
    input wire reset, // Async reset, active high
    input wire selStart, // MODE SELECT page start pulse
    input wire selByteValid, // Parameter byte strobe
    input wire [7:0] selByte, // Parameter byte
    input wire selEnd, // Last byte sent pulse
    input wire [63:0] capacityLba, // Returned capacity address
    input wire notchWr, // Active notch write pulse
    input wire [15:0] notchWrVal, // Active notch value
    input wire [15:0] notchStartCyl16, // Boundary source: unused high
    input wire [23:0] bndStartCyl, // Active notch first cylinder
    input wire [7:0] bndStartHead, // Active notch first head
    input wire [23:0] bndEndCyl, // Active notch last cylinder
    input wire [7:0] bndEndHead, // Active notch last head
    input wire senseReq, // Sense byte request pulse
    input wire [1:0] sensePage, // 0 tag, 1 notch, 2 protocol
    input wire [4:0] senseIdx, // Byte index
    input wire blkValid, // Block access strobe
    input wire [63:0] blkLba, // Block address
    input wire [15:0] blkTag, // Block application tag
    output reg selDone, // Select finished pulse
    output reg selCheck, // Check condition on select
    output reg [3:0] senseKey, // Sense key
    output reg [7:0] senseAsc, // Additional sense code
    output reg [7:0] senseAscq, // Additional sense qualifier
    output reg senseValid, // Sense byte ready pulse
    output reg [7:0] senseByte, // Sense byte
    output reg [15:0] notchSel, // Notch for dependent fields
    output reg tagDone, // Tag check pulse
    output reg tagHit, // Block under a descriptor
    output reg tagMismatch, // Tag compare failed
    output reg retryEnable // Transport retry use, always 0
);
    localparam ST_IDLE = 3'b001;
    localparam ST_RECV = 3'b010;
    localparam ST_DONE = 3'b100;
    localparam [15:0] MAX_NOTCH = `MPC_NP_MAX_NOTCH;
    ////////////////////////////////////////////////////////////////
    reg [2:0] state;
    reg [15:0] byteCnt;
    reg [4:0] descByte;
    reg [`MPC_AT_IDX_W:0] descNum;
    reg listEnded;
    reg bad;
    reg [63:0] expLba;
    reg [63:0] curLba;
    reg [63:0] curCnt;
    reg [15:0] curTag;
    reg curLast;
    reg [15:0] pageLen;
    reg [`MPC_AT_MAX_DESC-1:0] descUse;
    reg [64*`MPC_AT_MAX_DESC-1:0] descLbaFlat;
    reg [64*`MPC_AT_MAX_DESC-1:0] descCntFlat;
    reg [16*`MPC_AT_MAX_DESC-1:0] descTagFlat;
    wire [15:0] activeNotch;
    wire notchBad;
    wire chkDone;
    wire chkHit;
    wire chkMismatch;
    wire lastDescByte = selByteValid && descByte == 5'd23;
    wire [63:0] fullCnt = {curCnt[55:0], selByte};
    wire [63:0] endLba = curLba + fullCnt;
    // Last flagged descriptor closing in this very cycle
    wire endsNow = lastDescByte && !listEnded && curLast;
    ////////////////////////////////////////////////////////////////
    function [7:0] pick64;
        input [63:0] v;
        input [2:0] k;
        begin
            pick64 = v[8*(7-k) +: 8];
        end
    endfunction
    ////////////////////////////////////////////////////////////////
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
            byteCnt <= 16'h0000;
            descByte <= 5'd0;
            descNum <= {(`MPC_AT_IDX_W + 1){1'b0}};
            listEnded <= 1'b0;
            bad <= 1'b0;
            expLba <= 64'h0;
            curLba <= 64'h0;
            curCnt <= 64'h0;
            curTag <= 16'h0000;
            curLast <= 1'b0;
            pageLen <= 16'h0000;
            descUse <= {`MPC_AT_MAX_DESC{1'b0}};
            descLbaFlat <= {64*`MPC_AT_MAX_DESC{1'b0}};
            descCntFlat <= {64*`MPC_AT_MAX_DESC{1'b0}};
            descTagFlat <= {16*`MPC_AT_MAX_DESC{1'b0}};
            selDone <= 1'b0;
            selCheck <= 1'b0;
            senseKey <= 4'h0;
            senseAsc <= 8'h00;
            senseAscq <= 8'h00;
        end else begin
            selDone <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (selStart) begin
                        state <= ST_RECV;
                        byteCnt <= 16'h0000;
                        descByte <= 5'd0;
                        descNum <= {(`MPC_AT_IDX_W + 1){1'b0}};
                        descUse <= {`MPC_AT_MAX_DESC{1'b0}};
                        listEnded <= 1'b0;
                        bad <= 1'b0;
                        expLba <= 64'h0;
                    end
                end
                ST_RECV: begin
                    if (selByteValid) begin
                        byteCnt <= byteCnt + 16'h0001;
                        if (byteCnt == 16'h0000 && selByte[5:0] != `MPC_AT_PAGE_CODE)
                            bad <= 1'b1;
                        if (byteCnt == 16'h0001 && selByte != `MPC_AT_SUBPAGE)
                            bad <= 1'b1;
                        if (byteCnt == 16'h0002)
                            pageLen[15:8] <= selByte;
                        if (byteCnt == 16'h0003)
                            pageLen[7:0] <= selByte;
                        if (byteCnt >= `MPC_AT_HDR_BYTES) begin
                            descByte <= (descByte == 5'd23) ? 5'd0 : descByte + 5'd1;
                            if (descByte == 5'd0)
                                curLast <= selByte[`MPC_AT_LAST_BIT];
                            if (descByte == `MPC_AT_TAG_POS || descByte == `MPC_AT_TAG_POS + 1)
                                curTag <= {curTag[7:0], selByte};
                            if (descByte >= `MPC_AT_LBA_POS && descByte < `MPC_AT_CNT_POS)
                                curLba <= {curLba[55:0], selByte};
                            if (descByte >= `MPC_AT_CNT_POS)
                                curCnt <= {curCnt[55:0], selByte};
                        end
                        if (lastDescByte && !listEnded) begin
                            if (curLba != expLba)
                                bad <= 1'b1;
                            expLba <= endLba;
                            if (descNum < `MPC_AT_MAX_DESC) begin
                                descUse[descNum[`MPC_AT_IDX_W-1:0]] <= 1'b1;
                                descLbaFlat[64*descNum[`MPC_AT_IDX_W-1:0] +: 64] <= curLba;
                                descCntFlat[64*descNum[`MPC_AT_IDX_W-1:0] +: 64] <= fullCnt;
                                descTagFlat[16*descNum[`MPC_AT_IDX_W-1:0] +: 16] <= curTag;
                            end else begin
                                bad <= 1'b1;
                            end
                            descNum <= descNum + 1'b1;
                            if (curLast) begin
                                listEnded <= 1'b1;
                                if (endLba != capacityLba)
                                    bad <= 1'b1;
                            end
                        end
                    end
                    if (selEnd) begin
                        state <= ST_DONE;
                        if (!(listEnded || endsNow) || pageLen + `MPC_AT_LEN_ADJ != byteCnt
                            + (selByteValid ? 16'h0001 : 16'h0000))
                            bad <= 1'b1;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                    selDone <= 1'b1;
                    selCheck <= bad;
                    senseKey <= bad ? `MPC_SK_ILLEGAL_REQ : 4'h0;
                    senseAsc <= bad ? `MPC_ASC_INV_PARAM : 8'h00;
                    senseAscq <= bad ? `MPC_ASCQ_INV_PARAM : 8'h00;
                    if (bad)
                        descUse <= {`MPC_AT_MAX_DESC{1'b0}};
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    reg [7:0] next_senseByte;
    always @* begin
        next_senseByte = 8'h00;
        case (sensePage)
            2'd1: begin
                case (senseIdx)
                    5'd0: next_senseByte = `MPC_NP_PAGE_CODE;
                    5'd1: next_senseByte = `MPC_NP_PAGE_LEN;
                    5'd2: next_senseByte = `MPC_NP_BYTE2;
                    5'd4: next_senseByte = MAX_NOTCH[15:8];
                    5'd5: next_senseByte = MAX_NOTCH[7:0];
                    5'd6: next_senseByte = activeNotch[15:8];
                    5'd7: next_senseByte = activeNotch[7:0];
                    5'd8: next_senseByte = bndStartCyl[23:16];
                    5'd9: next_senseByte = bndStartCyl[15:8];
                    5'd10: next_senseByte = bndStartCyl[7:0];
                    5'd11: next_senseByte = bndStartHead;
                    5'd12: next_senseByte = bndEndCyl[23:16];
                    5'd13: next_senseByte = bndEndCyl[15:8];
                    5'd14: next_senseByte = bndEndCyl[7:0];
                    5'd15: next_senseByte = bndEndHead;
                    default: begin
                        if (senseIdx >= 5'd16 && senseIdx <= 5'd23)
                            next_senseByte = pick64(`MPC_NP_PAGES_NOTCHED, senseIdx[2:0] ^ 3'd0);
                    end
                endcase
            end
            2'd2: begin
                case (senseIdx)
                    5'd0: next_senseByte = `MPC_PL_PAGE_CODE;
                    5'd1: next_senseByte = `MPC_PL_PAGE_LEN;
                    5'd2: next_senseByte = {4'h0, `MPC_PL_PROTO_ID};
                    default: next_senseByte = 8'h00;
                endcase
            end
            default: begin
                case (senseIdx)
                    5'd0: next_senseByte = {2'b01, `MPC_AT_PAGE_CODE};
                    5'd1: next_senseByte = `MPC_AT_SUBPAGE;
                    default: next_senseByte = 8'h00;
                endcase
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            senseValid <= 1'b0;
            senseByte <= 8'h00;
            notchSel <= 16'h0000;
            tagDone <= 1'b0;
            tagHit <= 1'b0;
            tagMismatch <= 1'b0;
            retryEnable <= 1'b0;
        end else begin
            senseValid <= senseReq;
            if (senseReq)
                senseByte <= next_senseByte;
            notchSel <= activeNotch;
            tagDone <= chkDone;
            tagHit <= chkHit;
            tagMismatch <= chkMismatch;
            retryEnable <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////
    mpc_notch_regs uNotch (
        .clk(clk),
        .reset(reset),
        .notchWr(notchWr),
        .notchWrVal(notchWrVal),
        .activeNotch(activeNotch),
        .notchBad(notchBad)
    );
    mpc_tag_check uTag (
        .clk(clk),
        .reset(reset),
        .blkValid(blkValid),
        .blkLba(blkLba),
        .blkTag(blkTag),
        .descUse(descUse),
        .descLbaFlat(descLbaFlat),
        .descCntFlat(descCntFlat),
        .descTagFlat(descTagFlat),
        .chkDone(chkDone),
        .chkHit(chkHit),
        .chkMismatch(chkMismatch)
    );
endmodule // mpc_mode_page

// ### hdl/mpc_notch_regs.v
`timescale 1ns/1ps
`include "mpc_map.vh"
module mpc_notch_regs (
    input wire clk, // Clock
    input wire reset, // Async reset
    input wire notchWr, // Active notch write pulse
    input wire [15:0] notchWrVal, // Requested notch
    output reg [15:0] activeNotch, // Selected notch
    output reg notchBad // Last write out of range
);
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            activeNotch <= 16'h0000;
            notchBad <= 1'b0;
        end else if (notchWr) begin
            if (notchWrVal <= `MPC_NP_MAX_NOTCH) begin
                activeNotch <= notchWrVal;
                notchBad <= 1'b0;
            end else begin
                notchBad <= 1'b1;
            end
        end
    end
endmodule // mpc_notch_regs

// ### hdl/mpc_tag_check.v
`timescale 1ns/1ps
`include "mpc_map.vh"
module mpc_tag_check (
    input wire clk, // Clock
    input wire reset, // Async reset
    input wire blkValid, // Block access valid
    input wire [63:0] blkLba, // Block address
    input wire [15:0] blkTag, // Tag carried with data
    input wire [`MPC_AT_MAX_DESC-1:0] descUse, // Descriptor in use
    input wire [64*`MPC_AT_MAX_DESC-1:0] descLbaFlat, // Starts
    input wire [64*`MPC_AT_MAX_DESC-1:0] descCntFlat, // Counts
    input wire [16*`MPC_AT_MAX_DESC-1:0] descTagFlat, // Tags
    output reg chkDone, // Result pulse
    output reg chkHit, // Block covered
    output reg chkMismatch // Tag differs
);
    integer i;
    reg hit;
    reg miss;
    always @* begin
        hit = 1'b0;
        miss = 1'b0;
        for (i = 0; i < `MPC_AT_MAX_DESC; i = i + 1) begin
            if (descUse[i] && descCntFlat[64*i +: 64] != 64'h0 &&
                blkLba >= descLbaFlat[64*i +: 64] &&
                blkLba - descLbaFlat[64*i +: 64] < descCntFlat[64*i +: 64]) begin
                hit = 1'b1;
                miss = (blkTag != descTagFlat[16*i +: 16]);
            end
        end
    end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            chkDone <= 1'b0;
            chkHit <= 1'b0;
            chkMismatch <= 1'b0;
        end else begin
            chkDone <= blkValid;
            chkHit <= blkValid & hit;
            chkMismatch <= blkValid & hit & miss;
        end
    end
endmodule // mpc_tag_check

// ### verification/mpc_initiator_model.sv
`timescale 1ns/1ps
module mpc_initiator_model (
    input wire clk, // Clock
    output reg selStart, // Page start pulse
    output reg selByteValid, // Byte strobe
    output reg [7:0] selByte, // Byte
    output reg selEnd // Last byte pulse
);
    reg [63:0] dStart [0:2];
    reg [63:0] dCnt [0:2];
    reg [15:0] dTag [0:2];
    reg [2:0] dLast;
    integer nDesc = 3;
    initial begin
        selStart = 1'b0;
        selByteValid = 1'b0;
        selByte = 8'h00;
        selEnd = 1'b0;
    end
    function [7:0] page_byte(input integer i);
        integer d, o;
        reg [63:0] w;
        begin
            d = (i - 16) / 24;
            o = (i - 16) % 24;
            w = 64'h0;
            if (i == 0) w = 64'h4a;
            else if (i == 1) w = 64'h02;
            else if (i == 3) w = 12 + 24 * nDesc;
            else if (i >= 16 && o == 0) w = {dLast[d], 7'h00};
            else if (i >= 16 && o >= 6 && o < 8) w = dTag[d] >> (8 * (7 - o));
            else if (i >= 16 && o >= 8 && o < 16) w = dStart[d] >> (8 * (15 - o));
            else if (i >= 16 && o >= 16) w = dCnt[d] >> (8 * (23 - o));
            page_byte = w[7:0];
        end
    endfunction
    task send_page;
        integer i;
        begin
            @(negedge clk);
            selStart = 1'b1;
            @(negedge clk);
            selStart = 1'b0;
            for (i = 0; i < 16 + 24 * nDesc; i = i + 1) begin
                selByteValid = 1'b1;
                selByte = page_byte(i);
                selEnd = (i == 15 + 24 * nDesc);
                @(negedge clk);
            end
            selByteValid = 1'b0;
            selEnd = 1'b0;
            selByte = ~selByte;
        end
    endtask
endmodule // mpc_initiator_model

// ### verification/mpc_mode_page_assertions.sv
`timescale 1ns/1ps
module mpc_mode_page_checker (
    input wire clk, // Clock
    input wire reset, // Reset
    input wire selEnd, // Last byte
    input wire senseReq, // Sense request
    input wire blkValid, // Block strobe
    input wire notchWr, // Notch write
    input wire selDone, // Select done
    input wire selCheck, // Check condition
    input wire [3:0] senseKey, // Key
    input wire [7:0] senseAsc, // Code
    input wire [7:0] senseAscq, // Qualifier
    input wire senseValid, // Byte ready
    input wire [15:0] notchSel, // Notch
    input wire tagDone, // Tag done
    input wire tagHit, // Tag hit
    input wire tagMismatch, // Tag mismatch
    input wire retryEnable // Retry use
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_retry_never: assert property (retryEnable == 1'b0)
        else $error("retry enabled");
    a_check_sense: assert property (selCheck |-> senseKey == 4'h5
        && senseAsc == 8'h26 && senseAscq == 8'h00) else $error("bad check sense");
    a_clear_sense: assert property (!selCheck |-> {senseKey, senseAsc, senseAscq} == 20'h0)
        else $error("stray sense");
    a_done_bound: assert property (selEnd |-> ##[1:3] selDone)
        else $error("select never done");
    a_check_moves: assert property ($changed(selCheck) |-> selDone)
        else $error("check moved alone");
    a_sense_reply: assert property (senseReq |=> senseValid)
        else $error("no sense byte");
    a_tag_latency: assert property (blkValid |-> ##2 tagDone)
        else $error("tag result late");
    a_mis_hit: assert property (tagMismatch |-> tagHit && tagDone)
        else $error("mismatch without hit");
    a_notch_range: assert property (notchSel <= 16'h0010)
        else $error("notch out of range");
    a_notch_cause: assert property ($changed(notchSel) |-> $past(notchWr) || $past(notchWr, 2))
        else $error("notch moved alone");
endmodule // mpc_mode_page_checker
bind mpc_mode_page mpc_mode_page_checker chk_u (.clk(clk), .reset(reset), .selEnd(selEnd),
    .senseReq(senseReq), .blkValid(blkValid), .notchWr(notchWr), .selDone(selDone),
    .selCheck(selCheck), .senseKey(senseKey), .senseAsc(senseAsc), .senseAscq(senseAscq),
    .senseValid(senseValid), .notchSel(notchSel), .tagDone(tagDone), .tagHit(tagHit),
    .tagMismatch(tagMismatch), .retryEnable(retryEnable));

// ### verification/mpc_mode_page_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) check_val(nm, 64'(e), 64'(g));
module mpc_mode_page_tb;
    reg clk, reset, notchWr, senseReq, blkValid;
    reg [15:0] notchWrVal, blkTag;
    reg [1:0] sensePage;
    reg [4:0] senseIdx;
    reg [63:0] blkLba, capLba;
    reg [7:0] b;
    wire selStart, selByteValid, selEnd, selDone, selCheck, senseValid;
    wire tagDone, tagHit, tagMismatch, retryEnable;
    wire [7:0] selByte, senseByte, senseAsc, senseAscq;
    wire [3:0] senseKey;
    wire [15:0] notchSel;
    integer n_fail = 0, comparisons = 0, cycles = 0, i, c;
    localparam [191:0] NOTCH_EXP = {64'h0c16800000100003, 64'h12345607_89abcd0e,
        64'h0000_0000_0000_100c};
    localparam [63:0] PROTO_EXP = 64'h1806060000000000;
    mpc_mode_page dut_u (.clk(clk), .reset(reset), .selStart(selStart),
        .selByteValid(selByteValid), .selByte(selByte), .selEnd(selEnd),
        .capacityLba(capLba), .notchWr(notchWr), .notchWrVal(notchWrVal),
        .notchStartCyl16(16'h0000), .bndStartCyl(24'h123456), .bndStartHead(8'h07),
        .bndEndCyl(24'h89abcd), .bndEndHead(8'h0e), .senseReq(senseReq),
        .sensePage(sensePage), .senseIdx(senseIdx), .blkValid(blkValid), .blkLba(blkLba),
        .blkTag(blkTag), .selDone(selDone), .selCheck(selCheck), .senseKey(senseKey),
        .senseAsc(senseAsc), .senseAscq(senseAscq), .senseValid(senseValid),
        .senseByte(senseByte), .notchSel(notchSel), .tagDone(tagDone), .tagHit(tagHit),
        .tagMismatch(tagMismatch), .retryEnable(retryEnable));
    mpc_initiator_model partner_u (.clk(clk), .selStart(selStart),
        .selByteValid(selByteValid), .selByte(selByte), .selEnd(selEnd));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task check_val(input string nm, input logic [63:0] e, input logic [63:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("[FAIL] %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task close_out;
        begin
            $display("comparisons %0d n_fail %0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            close_out;
        end
    end
    task sense_rd(input [1:0] pg, input integer ix);
        integer k;
        begin
            @(negedge clk);
            sensePage = pg;
            senseIdx = ix[4:0];
            senseReq = 1'b1;
            @(negedge clk);
            senseReq = 1'b0;
            for (k = 0; k < 4 && senseValid !== 1'b1; k = k + 1) @(negedge clk);
            b = senseByte;
        end
    endtask
    task nw(input [15:0] v);
        begin
            @(negedge clk);
            notchWr = 1'b1;
            notchWrVal = v;
            @(negedge clk);
            notchWr = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask
    task sel_run(input expChk);
        integer k;
        begin
            partner_u.send_page;
            for (k = 0; k < 200 && selDone !== 1'b1; k = k + 1) @(negedge clk);
            `CHK("selCheck", expChk, selCheck)
            `CHK("senseKey", expChk ? 4'h5 : 4'h0, senseKey)
            `CHK("senseAsc", expChk ? 8'h26 : 8'h00, senseAsc)
        end
    endtask
    task blk(input [63:0] lba, input [15:0] tag, input eh, input em);
        integer k;
        begin
            @(negedge clk);
            blkLba = lba;
            blkTag = tag;
            blkValid = 1'b1;
            @(negedge clk);
            blkValid = 1'b0;
            for (k = 0; k < 4 && tagDone !== 1'b1; k = k + 1) @(negedge clk);
            `CHK("tagHit", eh, tagHit)
            `CHK("tagMismatch", em, tagMismatch)
        end
    endtask
    task set_good;
        begin
            partner_u.dStart[0] = 0;
            partner_u.dCnt[0] = 100;
            partner_u.dTag[0] = 16'haaaa;
            partner_u.dStart[1] = 100;
            partner_u.dCnt[1] = 0;
            partner_u.dTag[1] = 16'hbbbb;
            partner_u.dStart[2] = 100;
            partner_u.dCnt[2] = 156;
            partner_u.dTag[2] = 16'hcccc;
            partner_u.dLast = 3'b100;
        end
    endtask
    initial begin
        reset = 1'b1;
        {notchWr, senseReq, blkValid, notchWrVal, blkTag, sensePage, senseIdx} = 0;
        blkLba = 64'h0;
        capLba = 64'd256;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        `CHK("retryEnable", 1'b0, retryEnable)
        for (i = 0; i < 8; i = i + 1) begin
            sense_rd(2'd2, i);
            `CHK("protoByte", PROTO_EXP[63 - 8 * i -: 8], b)
        end
        nw(16'h0003);
        `CHK("notchSel", 16'h0003, notchSel)
        nw(16'h0011);
        `CHK("notchSel", 16'h0003, notchSel)
        for (i = 0; i < 24; i = i + 1) begin
            sense_rd(2'd1, i);
            `CHK("notchByte", NOTCH_EXP[191 - 8 * i -: 8], b)
        end
        nw(16'h0010);
        `CHK("notchSel", 16'h0010, notchSel)
        nw(16'h0000);
        `CHK("notchSel", 16'h0000, notchSel)
        set_good;
        sel_run(1'b0);
        blk(64'd99, 16'haaaa, 1'b1, 1'b0);
        blk(64'd100, 16'hbbbb, 1'b1, 1'b1);
        blk(64'd255, 16'hcccc, 1'b1, 1'b0);
        blk(64'd256, 16'hcccc, 1'b0, 1'b0);
        for (c = 0; c < 4; c = c + 1) begin
            set_good;
            case (c)
                0: partner_u.dStart[0] = 1;
                1: partner_u.dStart[2] = 101;
                2: partner_u.dLast = 3'b000;
                default: partner_u.dCnt[2] = 157;
            endcase
            sel_run(1'b1);
            blk(64'd0, 16'haaaa, 1'b0, 1'b0);
        end
        capLba = 64'd257;
        set_good;
        partner_u.dCnt[2] = 157;
        sel_run(1'b0);
        blk(64'd256, 16'hcccc, 1'b1, 1'b0);
        close_out;
    end
endmodule // mpc_mode_page_tb
